// >>> logic/fsr_pkg.sv
// constants, beat layout and capture helper shared by both bus ends
// assumes both ends see the same shared bus clock on the link side
package fsr_pkg;
  // ****************************************
  // widths and groups
  // ****************************************
  localparam int ADDR_W = 29;
  localparam int REQ_W = 5;
  localparam int LO_W = 14;
  localparam int BRK_W = 4;
  localparam int SEL_W = 2;
  localparam int STB_W = 2;
  localparam int STB_LO = 0;
  localparam int STB_HI = 1;
  localparam int GUARD_W = 2;
  // ****************************************
  // timing and codes
  // ****************************************
  localparam int BUS_CLK_MHZ = 133;
  localparam int BUS_RATE_MTS = 533;
  localparam logic [GUARD_W-1:0] GUARD_CYC = 2'h3;
  localparam logic [SEL_W-1:0] FREQ_SEL_DEF = 2'h1;
  localparam logic [STB_W-1:0] STB_IDLE = 2'h3;
  localparam logic [STB_W-1:0] STB_FALL = 2'h0;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REQ_W-1:0] cmd;
  } fsr_beat_t;
  typedef struct packed {
    fsr_beat_t b0;
    fsr_beat_t b1;
  } fsr_req_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_BEAT0 = 2'h1,
    TX_BEAT1 = 2'h2
  } fsr_tx_t;
  localparam fsr_beat_t BEAT_IDLE = '1;
  // ****************************************
  // capture one strobe group, lines are active low
  // ****************************************
  function automatic fsr_beat_t fsr_grab(fsr_beat_t cur, fsr_beat_t pins, logic hiGroup);
    fsr_beat_t r;
    r = cur;
    if (hiGroup) begin
      r.addr[ADDR_W-1:LO_W] = ~pins.addr[ADDR_W-1:LO_W];
    end else begin
      r.addr[LO_W-1:0] = ~pins.addr[LO_W-1:0];
      r.cmd = ~pins.cmd;
    end
    return r;
  endfunction
endpackage

// >>> logic/fsr_link_if.sv
// link between the processor end and the hub end
// assumes a pull-up on every shared line; undriven lines read high
interface fsr_link_if (
  input wire logic busClk
);
  import fsr_pkg::*;
  fsr_beat_t cpuBeat;
  fsr_beat_t hubBeat;
  fsr_beat_t busBeat;
  logic cpuBeatOe;
  logic hubBeatOe;
  logic [STB_W-1:0] cpuAddrStrobe;
  logic [STB_W-1:0] hubAddrStrobe;
  logic [STB_W-1:0] busAddrStrobe;
  logic cpuBlockNext_n;
  logic cpuBlockNextOe;
  logic hubBlockNext_n;
  logic hubBlockNextOe;
  logic blockNextRequest_n;
  logic priorityRequest_n;
  logic [BRK_W-1:0] breakpointMonitor_n;
  logic [SEL_W-1:0] busFreqSelect;
  // ****************************************
  // wire resolution
  // ****************************************
  assign busBeat = cpuBeatOe ? cpuBeat : (hubBeatOe ? hubBeat : BEAT_IDLE);
  assign busAddrStrobe = cpuBeatOe ? cpuAddrStrobe : (hubBeatOe ? hubAddrStrobe : STB_IDLE);
  assign blockNextRequest_n = (cpuBlockNextOe ? cpuBlockNext_n : 1'b1)
                            & (hubBlockNextOe ? hubBlockNext_n : 1'b1);
  modport cpu (
    input busClk, busBeat, busAddrStrobe, blockNextRequest_n, priorityRequest_n,
    output cpuBeat, cpuBeatOe, cpuAddrStrobe, cpuBlockNext_n, cpuBlockNextOe,
    output breakpointMonitor_n, busFreqSelect
  );
  modport hub (
    input busClk, busBeat, busAddrStrobe, blockNextRequest_n,
    input breakpointMonitor_n, busFreqSelect,
    output hubBeat, hubBeatOe, hubAddrStrobe, hubBlockNext_n, hubBlockNextOe,
    output priorityRequest_n
  );
endinterface

// >>> logic/fsr_cpu_end.sv
// processor end of the request bus: sends, receives, monitor pins
// assumes sys_clk and the link bus clock are unrelated
//
// How it works
// - strobe 0: request, low address; strobe 1: high
// - capture on falling and rising strobe edges
// - link logic runs on shared bus clock only
// - block-next asserted stops every new request
// - drive breakpoint monitor status pins
// - priority request stops new requests unless the last one sent was locked and the quiet count is still below 2
// - priority agent holds request until done
// - report clock select, bus at 133 MHz
module fsr_cpu_end #(
  parameter logic [fsr_pkg::SEL_W-1:0] FREQ_CODE = fsr_pkg::FREQ_SEL_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  fsr_link_if.cpu link,
  // outgoing requests
  input wire logic reqValid,
  output logic reqReady,
  input wire fsr_pkg::fsr_req_t reqData,
  input wire logic reqLock,
  // incoming requests
  output logic rxValid,
  output fsr_pkg::fsr_req_t rxData,
  // monitor status
  input wire logic [fsr_pkg::BRK_W-1:0] brkStatus
);
  import fsr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fsr_req_t txHold;
    logic txLock;
    logic txTgl;
    logic ackS1;
    logic ackS2;
    logic ready;
    logic rxS1;
    logic rxS2;
    logic rxSeen;
    logic rxValid;
    fsr_req_t rxData;
  } fsr_cpu_sys_t;

  typedef struct packed {
    fsr_tx_t st;
    logic ackTgl;
    logic txS1;
    logic txS2;
    logic lockAct;
    logic [GUARD_W-1:0] quiet;
    fsr_beat_t beat;
    logic beatOe;
    logic [STB_W-1:0] stb;
    logic [STB_W-1:0] stbPrev;
    fsr_req_t rxHold;
    logic rxTgl;
    logic seenS1;
    logic seenS2;
    logic blockOe;
    logic blockOut_n;
    logic [BRK_W-1:0] brkS1;
    logic [BRK_W-1:0] brkS2;
    logic [BRK_W-1:0] brkOut_n;
    logic [SEL_W-1:0] sel;
  } fsr_cpu_link_t;

  fsr_cpu_sys_t s_q;
  fsr_cpu_sys_t s_d;
  fsr_cpu_link_t l_q;
  fsr_cpu_link_t l_d;
  logic txPend;
  logic mayGo;

  // ****************************************
  // user side, sys_clk
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.ackS1 = l_q.ackTgl;
    s_d.ackS2 = s_q.ackS1;
    s_d.rxS1 = l_q.rxTgl;
    s_d.rxS2 = s_q.rxS1;
    s_d.rxValid = 1'b0;
    // take a request, hold it until the link end acknowledges
    if (reqValid && s_q.ready) begin
      s_d.txHold = reqData;
      s_d.txLock = reqLock;
      s_d.txTgl = ~s_q.txTgl;
    end
    s_d.ready = (s_d.txTgl == s_d.ackS2);
    // hand a received request to the user, free the receive hold
    if (s_q.rxS2 != s_q.rxSeen) begin
      s_d.rxValid = 1'b1;
      s_d.rxData = l_q.rxHold;
      s_d.rxSeen = s_q.rxS2;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // link side, bus clock
  // ****************************************
  assign txPend = (l_q.txS2 != l_q.ackTgl);
  assign mayGo = link.blockNextRequest_n
               && (link.priorityRequest_n
                   || (l_q.lockAct && l_q.quiet < GUARD_CYC - 1'b1));

  always_comb begin
    l_d = l_q;
    l_d.txS1 = s_q.txTgl;
    l_d.txS2 = l_q.txS1;
    l_d.seenS1 = s_q.rxSeen;
    l_d.seenS2 = l_q.seenS1;
    l_d.brkS1 = brkStatus;
    l_d.brkS2 = l_q.brkS1;
    l_d.brkOut_n = ~l_q.brkS2;
    l_d.sel = FREQ_CODE;
    l_d.stbPrev = link.busAddrStrobe;
    // mirror of the hub quiet count, locked starts stop before its guard ends
    if (link.busAddrStrobe != STB_IDLE || link.priorityRequest_n) begin
      l_d.quiet = '0;
    end else if (l_q.quiet != GUARD_CYC) begin
      l_d.quiet = l_q.quiet + 1'b1;
    end
    // receive the two beats of a request from the far end
    if (!l_q.beatOe) begin
      for (int i = 0; i < STB_W; i++) begin
        if (l_q.stbPrev[i] && !link.busAddrStrobe[i]) begin
          l_d.rxHold.b0 = fsr_grab(l_d.rxHold.b0, link.busBeat, i == STB_HI);
        end
        if (!l_q.stbPrev[i] && link.busAddrStrobe[i]) begin
          l_d.rxHold.b1 = fsr_grab(l_d.rxHold.b1, link.busBeat, i == STB_HI);
        end
      end
      if (!l_q.stbPrev[STB_HI] && link.busAddrStrobe[STB_HI]) begin
        l_d.rxTgl = ~l_q.rxTgl;
      end
    end
    // refuse new requests while the receive hold is full
    l_d.blockOe = (l_d.rxTgl != l_d.seenS2);
    l_d.blockOut_n = ~l_d.blockOe;
    // send: falling strobes carry beat 0, rising strobes beat 1
    case (l_q.st)
      TX_IDLE: begin
        if (txPend && mayGo) begin
          l_d.st = TX_BEAT0;
          l_d.beatOe = 1'b1;
          l_d.beat = ~s_q.txHold.b0;
          l_d.stb = STB_FALL;
          l_d.lockAct = s_q.txLock;
        end
      end
      TX_BEAT0: begin
        l_d.st = TX_BEAT1;
        l_d.beat = ~s_q.txHold.b1;
        l_d.stb = STB_IDLE;
      end
      TX_BEAT1: begin
        l_d.st = TX_IDLE;
        l_d.beatOe = 1'b0;
        l_d.beat = BEAT_IDLE;
        l_d.ackTgl = ~l_q.ackTgl;
      end
      default: begin
        l_d.st = TX_IDLE;
        l_d.beatOe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link.busClk or negedge rst_n) begin
    if (!rst_n) begin
      l_q <= '0;
      l_q.beat <= BEAT_IDLE;
      l_q.stb <= STB_IDLE;
      l_q.stbPrev <= STB_IDLE;
      l_q.blockOut_n <= 1'b1;
      l_q.brkOut_n <= '1;
      l_q.sel <= FREQ_CODE;
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reqReady = s_q.ready;
  assign rxValid = s_q.rxValid;
  assign rxData = s_q.rxData;
  assign link.cpuBeat = l_q.beat;
  assign link.cpuBeatOe = l_q.beatOe;
  assign link.cpuAddrStrobe = l_q.stb;
  assign link.cpuBlockNext_n = l_q.blockOut_n;
  assign link.cpuBlockNextOe = l_q.blockOe;
  assign link.breakpointMonitor_n = l_q.brkOut_n;
  assign link.busFreqSelect = l_q.sel;

endmodule // fsr_cpu_end

// >>> logic/fsr_hub_end.sv
// hub end of the request bus: priority agent, monitor observer
// assumes sys_clk and the link bus clock are unrelated
module fsr_hub_end (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  fsr_link_if.hub link,
  // outgoing requests
  input wire logic reqValid,
  output logic reqReady,
  input wire fsr_pkg::fsr_req_t reqData,
  // incoming requests
  output logic rxValid,
  output fsr_pkg::fsr_req_t rxData,
  // observed status
  output logic [fsr_pkg::BRK_W-1:0] brkSeen,
  output logic [fsr_pkg::SEL_W-1:0] freqSeen,
  output logic busOwned
);
  import fsr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fsr_req_t txHold;
    logic txTgl;
    logic ackS1;
    logic ackS2;
    logic ready;
    logic rxS1;
    logic rxS2;
    logic rxSeen;
    logic rxValid;
    fsr_req_t rxData;
    logic [BRK_W-1:0] brkS1;
    logic [BRK_W-1:0] brkS2;
    logic [SEL_W-1:0] selS1;
    logic [SEL_W-1:0] selS2;
    logic [BRK_W-1:0] brk;
    logic [SEL_W-1:0] sel;
  } fsr_hub_sys_t;

  typedef struct packed {
    fsr_tx_t st;
    logic ackTgl;
    logic txS1;
    logic txS2;
    logic prio;
    logic [GUARD_W-1:0] quiet;
    fsr_beat_t beat;
    logic beatOe;
    logic [STB_W-1:0] stb;
    logic [STB_W-1:0] stbPrev;
    fsr_req_t rxHold;
    logic rxTgl;
    logic seenS1;
    logic seenS2;
    logic blockOe;
    logic blockOut_n;
  } fsr_hub_link_t;

  fsr_hub_sys_t s_q;
  fsr_hub_sys_t s_d;
  fsr_hub_link_t l_q;
  fsr_hub_link_t l_d;
  logic txPend;

  // ****************************************
  // user side, sys_clk
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.ackS1 = l_q.ackTgl;
    s_d.ackS2 = s_q.ackS1;
    s_d.rxS1 = l_q.rxTgl;
    s_d.rxS2 = s_q.rxS1;
    s_d.brkS1 = link.breakpointMonitor_n;
    s_d.brkS2 = s_q.brkS1;
    s_d.brk = ~s_q.brkS2;
    s_d.selS1 = link.busFreqSelect;
    s_d.selS2 = s_q.selS1;
    s_d.sel = s_q.selS2;
    s_d.rxValid = 1'b0;
    if (reqValid && s_q.ready) begin
      s_d.txHold = reqData;
      s_d.txTgl = ~s_q.txTgl;
    end
    s_d.ready = (s_d.txTgl == s_d.ackS2);
    if (s_q.rxS2 != s_q.rxSeen) begin
      s_d.rxValid = 1'b1;
      s_d.rxData = l_q.rxHold;
      s_d.rxSeen = s_q.rxS2;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // link side, bus clock
  // ****************************************
  assign txPend = (l_q.txS2 != l_q.ackTgl);

  always_comb begin
    l_d = l_q;
    l_d.txS1 = s_q.txTgl;
    l_d.txS2 = l_q.txS1;
    l_d.seenS1 = s_q.rxSeen;
    l_d.seenS2 = l_q.seenS1;
    l_d.stbPrev = link.busAddrStrobe;
    if (!l_q.beatOe) begin
      for (int i = 0; i < STB_W; i++) begin
        if (l_q.stbPrev[i] && !link.busAddrStrobe[i]) begin
          l_d.rxHold.b0 = fsr_grab(l_d.rxHold.b0, link.busBeat, i == STB_HI);
        end
        if (!l_q.stbPrev[i] && link.busAddrStrobe[i]) begin
          l_d.rxHold.b1 = fsr_grab(l_d.rxHold.b1, link.busBeat, i == STB_HI);
        end
      end
      if (!l_q.stbPrev[STB_HI] && link.busAddrStrobe[STB_HI]) begin
        l_d.rxTgl = ~l_q.rxTgl;
      end
    end
    l_d.blockOe = (l_d.rxTgl != l_d.seenS2);
    l_d.blockOut_n = ~l_d.blockOe;
    // quiet bus count after taking priority
    if (link.busAddrStrobe != STB_IDLE || !l_q.prio) begin
      l_d.quiet = '0;
    end else if (l_q.quiet != GUARD_CYC) begin
      l_d.quiet = l_q.quiet + 1'b1;
    end
    // hold priority until every own request has gone out
    if (!l_q.prio) begin
      l_d.prio = txPend;
    end else if (!txPend && l_q.st == TX_IDLE) begin
      l_d.prio = 1'b0;
    end
    case (l_q.st)
      TX_IDLE: begin
        if (txPend && l_q.prio && l_q.quiet == GUARD_CYC && link.blockNextRequest_n) begin
          l_d.st = TX_BEAT0;
          l_d.beatOe = 1'b1;
          l_d.beat = ~s_q.txHold.b0;
          l_d.stb = STB_FALL;
        end
      end
      TX_BEAT0: begin
        l_d.st = TX_BEAT1;
        l_d.beat = ~s_q.txHold.b1;
        l_d.stb = STB_IDLE;
      end
      TX_BEAT1: begin
        l_d.st = TX_IDLE;
        l_d.beatOe = 1'b0;
        l_d.beat = BEAT_IDLE;
        l_d.ackTgl = ~l_q.ackTgl;
      end
      default: begin
        l_d.st = TX_IDLE;
        l_d.beatOe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link.busClk or negedge rst_n) begin
    if (!rst_n) begin
      l_q <= '0;
      l_q.beat <= BEAT_IDLE;
      l_q.stb <= STB_IDLE;
      l_q.stbPrev <= STB_IDLE;
      l_q.blockOut_n <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reqReady = s_q.ready;
  assign rxValid = s_q.rxValid;
  assign rxData = s_q.rxData;
  assign brkSeen = s_q.brk;
  assign freqSeen = s_q.sel;
  assign busOwned = l_q.prio;
  assign link.hubBeat = l_q.beat;
  assign link.hubBeatOe = l_q.beatOe;
  assign link.hubAddrStrobe = l_q.stb;
  assign link.hubBlockNext_n = l_q.blockOut_n;
  assign link.hubBlockNextOe = l_q.blockOe;
  assign link.priorityRequest_n = ~l_q.prio;

endmodule // fsr_hub_end

// >>> verification/fsr_link_properties.sv
// link checker: strobe framing, block-next and priority ownership
// assumes tb_top wires the link lines and the bench reset to it
module fsr_link_properties #(
  parameter logic [fsr_pkg::SEL_W-1:0] FREQ_CODE = fsr_pkg::FREQ_SEL_DEF
) (
  // clock and reset
  input wire logic busClk,
  input wire logic rst_n,
  // link lines
  input wire logic [fsr_pkg::STB_W-1:0] busAddrStrobe,
  input wire logic cpuBeatOe,
  input wire logic hubBeatOe,
  input wire logic blockNextRequest_n,
  input wire logic priorityRequest_n,
  input wire logic [fsr_pkg::SEL_W-1:0] busFreqSelect
);
  import fsr_pkg::*;
  default clocking cb @(posedge busClk); endclocking
  default disable iff (!rst_n);
  // ************
  // transfer shapes
  // ************
  sequence sBeats(oe);
    busAddrStrobe == STB_FALL && oe ##1 busAddrStrobe == STB_IDLE && oe ##1 !oe;
  endsequence
  sequence sDone(oe);
    $rose(oe) ##2 $fell(oe);
  endsequence
  // ************
  // checks
  // ************
  a_cpu_beat_shape: assert property ($rose(cpuBeatOe) |-> sBeats(cpuBeatOe))
    else $error("cpu transfer framing wrong");
  a_hub_beat_shape: assert property ($rose(hubBeatOe) |-> sBeats(hubBeatOe))
    else $error("hub transfer framing wrong");
  a_single_driver: assert property (!(cpuBeatOe && hubBeatOe))
    else $error("both ends drive the link");
  a_block_stops_start: assert property (
    $rose(cpuBeatOe) || $rose(hubBeatOe) |-> $past(blockNextRequest_n))
    else $error("transfer started while blocked");
  a_cpu_recv_blocks: assert property (sDone(cpuBeatOe) |=> !blockNextRequest_n)
    else $error("hub did not block after receiving");
  a_hub_recv_blocks: assert property (sDone(hubBeatOe) |=> !blockNextRequest_n)
    else $error("cpu did not block after receiving");
  a_hub_owns_bus: assert property ($rose(hubBeatOe) |-> !priorityRequest_n [*3])
    else $error("hub sent without holding priority");
  a_hub_guard_gap: assert property (
    $rose(hubBeatOe) |-> $past(priorityRequest_n, 3) == 1'b0)
    else $error("hub drove too soon after priority");
  a_prio_release: assert property ($rose(priorityRequest_n) |-> !hubBeatOe)
    else $error("priority released mid transfer");
  a_freq_fixed: assert property (busFreqSelect == FREQ_CODE)
    else $error("bus select code changed");
endmodule // fsr_link_properties

// >>> verification/tb_top.sv
// self-checking bench: both request bus ends joined over the link
// assumes package, link interface and both ends compile first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fsr_pkg::*;
  logic sys_clk = 1'b0;
  logic busClk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] valid = 2'h0;
  logic cpuLock = 1'b0;
  logic [BRK_W-1:0] brkStatus = 4'h0;
  fsr_req_t txData [2];
  wire [1:0] ready;
  wire [1:0] rxValid;
  wire fsr_req_t cpuRx;
  wire fsr_req_t hubRx;
  wire [BRK_W-1:0] brkSeen;
  wire [SEL_W-1:0] freqSeen;
  wire busOwned;
  int nErrors = 0;
  int checksDone = 0;
  fsr_req_t expQ [2][$];
  always #20 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #15 busClk = ~busClk;
  end
  // ************
  // design and checker
  // ************
  fsr_link_if link (.busClk(busClk));
  fsr_cpu_end i_fsr_cpu_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .reqValid(valid[0]), .reqReady(ready[0]), .reqData(txData[0]), .reqLock(cpuLock),
    .rxValid(rxValid[0]), .rxData(cpuRx), .brkStatus(brkStatus));
  fsr_hub_end i_fsr_hub_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .reqValid(valid[1]), .reqReady(ready[1]), .reqData(txData[1]),
    .rxValid(rxValid[1]), .rxData(hubRx), .brkSeen(brkSeen), .freqSeen(freqSeen),
    .busOwned(busOwned));
  fsr_link_properties #(.FREQ_CODE(FREQ_SEL_DEF)) u_props (.busClk(busClk),
    .rst_n(rst_n), .busAddrStrobe(link.busAddrStrobe), .cpuBeatOe(link.cpuBeatOe),
    .hubBeatOe(link.hubBeatOe), .blockNextRequest_n(link.blockNextRequest_n),
    .priorityRequest_n(link.priorityRequest_n), .busFreqSelect(link.busFreqSelect));
  // ************
  // helpers
  // ************
  task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic fsr_req_t rnd();
    logic [95:0] v;
    v = {$urandom(), $urandom(), $urandom()};
    return v[67:0];
  endfunction
  // one user request from end e (0 cpu, 1 hub), then watch its beats on the wire
  task automatic send(input int e, input fsr_req_t d, input logic lk);
    int i;
    @(posedge sys_clk);
    for (i = 0; i < 500 && ready[e] !== 1'b1; i++) @(posedge sys_clk);
    valid[e] <= 1'b1;
    txData[e] <= d;
    if (e == 0) cpuLock <= lk;
    @(posedge sys_clk);
    valid[e] <= 1'b0;
    expQ[e].push_back(d);
    for (i = 0; i < 600 && (e ? link.hubBeatOe : link.cpuBeatOe) !== 1'b1; i++)
      @(negedge busClk);
    chk(link.busBeat, fsr_beat_t'(~d.b0));
    chk(link.busAddrStrobe, STB_FALL);
    if (e == 1) chk({busOwned, link.priorityRequest_n}, 2'h2);
    @(negedge busClk);
    chk(link.busBeat, fsr_beat_t'(~d.b1));
    chk(link.busAddrStrobe, STB_IDLE);
  endtask
  // receive side model: in-order delivery per direction
  always @(posedge sys_clk) begin
    if (rxValid[1] === 1'b1) chk(hubRx, expQ[0].size() ? expQ[0].pop_front() : ~hubRx);
    if (rxValid[0] === 1'b1) chk(cpuRx, expQ[1].size() ? expQ[1].pop_front() : ~cpuRx);
  end
  // ************
  // scenarios
  // ************
  initial begin
    int k;
    txData[0] = '0;
    txData[1] = '0;
    void'($urandom(32'hc13f_b818));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    send(0, '0, 1'b0);
    send(1, '1, 1'b0);
    for (k = 0; k < 5; k++) send(0, rnd(), 1'b0);
    for (k = 0; k < 4; k++) send(1, rnd(), 1'b0);
    for (k = 0; k < 4; k++) begin
      fork
        send(0, rnd(), 1'b0);
        send(1, rnd(), 1'b0);
      join
    end
    fork
      begin
        send(0, rnd(), 1'b1);
        send(0, rnd(), 1'b1);
        send(0, rnd(), 1'b0);
      end
      repeat (3) send(1, rnd(), 1'b0);
    join
    for (k = 0; k < 4; k++) begin
      brkStatus <= BRK_W'($urandom());
      repeat (30) @(posedge sys_clk);
      chk(brkSeen, brkStatus);
      chk(link.breakpointMonitor_n, BRK_W'(~brkStatus));
    end
    chk({freqSeen, link.busFreqSelect}, {FREQ_SEL_DEF, FREQ_SEL_DEF});
    chk({busOwned, link.blockNextRequest_n}, 2'h1);
    chk(expQ[0].size() + expQ[1].size(), 68'h0);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({ready, rxValid, busOwned, link.priorityRequest_n}, 6'h01);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(ready, 2'h3);
    send(1, rnd(), 1'b0);
    send(0, rnd(), 1'b0);
    repeat (200) @(posedge sys_clk);
    chk(expQ[0].size() + expQ[1].size(), 68'h0);
    print_verdict();
  end
  initial begin
    #3_000_000;
    nErrors++;
    print_verdict();
  end
endmodule // tb_top
